/* File: rtl/hco_pkg.sv */
// Package for the hardware cursor overlay: register map, fields, reset values, types
package hco_pkg;
    // ********************************************************
    // Register byte addresses on APB
    // ********************************************************
    localparam logic [7:0] ADDR_LOCK      = 8'h00;
    localparam logic [7:0] ADDR_MODE      = 8'h04;
    localparam logic [7:0] ADDR_X_HIGH    = 8'h08;
    localparam logic [7:0] ADDR_X_LOW     = 8'h0c;
    localparam logic [7:0] ADDR_Y_HIGH    = 8'h10;
    localparam logic [7:0] ADDR_Y_LOW     = 8'h14;
    localparam logic [7:0] ADDR_FG_STACK  = 8'h18;
    localparam logic [7:0] ADDR_BG_STACK  = 8'h1c;
    localparam logic [7:0] ADDR_SEG_HIGH  = 8'h20;
    localparam logic [7:0] ADDR_SEG_LOW   = 8'h24;
    localparam logic [7:0] ADDR_X_OFFSET  = 8'h28;
    localparam logic [7:0] ADDR_Y_OFFSET  = 8'h2c;
    localparam logic [7:0] ADDR_DAC_CTRL  = 8'h30;
    localparam logic [7:0] ADDR_ADV_FUNC  = 8'h34;

    // ********************************************************
    // Field layout and constants
    // ********************************************************
    localparam logic [7:0] UNLOCK_KEY     = 8'ha0;
    localparam logic [7:0] REG_RESET      = 8'h00;
    localparam int         ENABLE_BIT     = 0;
    localparam int         CONVENTION_BIT = 4;
    localparam int         ENHANCED_BIT   = 0;
    localparam logic [1:0] STACK_LAST     = 2'h2;
    localparam logic [1:0] STACK_FIRST    = 2'h0;
    localparam int         POS_W          = 11;
    localparam int         OFF_W          = 6;
    localparam int         SEG_W          = 12;
    localparam int         MEM_AW         = 22;
    localparam logic [11:0] CURSOR_SIZE   = 12'h040;
    localparam logic [10:0] SCREEN_H      = 11'h300;
    localparam logic [MEM_AW-1:0] XOR_MASK_OFS = 22'h000200;
    localparam int         SEG_SHIFT      = 10;
    localparam int         ROW_SHIFT      = 3;

    // ********************************************************
    // Types
    // ********************************************************
    typedef struct packed {
        logic        active;
        logic [23:0] rgb;
    } hco_pix_t;

    typedef struct packed {
        logic [POS_W-1:0] x;
        logic [POS_W-1:0] y;
        logic [OFF_W-1:0] xoff;
        logic [OFF_W-1:0] yoff;
    } hco_pos_t;

    typedef enum logic [1:0] {
        FT_IDLE,
        FT_AND,
        FT_XOR
    } hco_fetch_t;
endpackage

/* File: rtl/hco_overlay.sv */
// Hardware cursor overlay: APB registers, per-line mask fetch and pixel combiner
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module hco_overlay (
    // Clock and reset
    input  wire logic                           ref_clk,
    input  wire logic                           reset_n,
    // APB slave
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [7:0]                     paddr,
    input  wire logic [31:0]                    pwdata,
    output var  logic [31:0]                    prdata,
    output var  logic                           pready,
    output var  logic                           pslverr,
    // Display timing, same clock domain
    input  wire logic                           frame_start,
    input  wire logic                           line_fetch,
    input  wire logic [hco_pkg::POS_W-1:0]      line_y,
    input  wire logic [hco_pkg::POS_W-1:0]      pix_x,
    input  wire hco_pkg::hco_pix_t              pix_in,
    // Overlaid pixel stream
    output var  hco_pkg::hco_pix_t              pix_out,
    // Display memory read port
    output var  logic                           mem_req,
    output var  logic [hco_pkg::MEM_AW-1:0]     mem_addr,
    input  wire logic                           mem_ack,
    input  wire logic [63:0]                    mem_rdata
);
    // ********************************************************
    // Reset release
    // ********************************************************
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // ********************************************************
    // Address decode
    // ********************************************************
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a <= hco_pkg::ADDR_ADV_FUNC) && (a[1:0] == 2'h0);
    endfunction

    function automatic logic is_locked_reg(input logic [7:0] a);
        // Lock, convention and enhanced-mode registers stay writable when locked
        is_locked_reg = (a != hco_pkg::ADDR_LOCK) && (a != hco_pkg::ADDR_DAC_CTRL) &&
                        (a != hco_pkg::ADDR_ADV_FUNC);
    endfunction

    // ********************************************************
    // Register file and APB answer
    // ********************************************************
    logic [7:0]  lock_q, lock_d;
    logic [7:0]  mode_q, mode_d;
    logic [7:0]  xh_q, xh_d;
    logic [7:0]  xl_q, xl_d;
    logic [7:0]  yh_q, yh_d;
    logic [7:0]  yl_q, yl_d;
    logic [7:0]  segh_q, segh_d;
    logic [7:0]  segl_q, segl_d;
    logic [7:0]  xoff_q, xoff_d;
    logic [7:0]  yoff_q, yoff_d;
    logic [7:0]  dac_q, dac_d;
    logic [7:0]  adv_q, adv_d;
    logic [7:0]  fg_q [3];
    logic [7:0]  fg_d [3];
    logic [7:0]  bg_q [3];
    logic [7:0]  bg_d [3];
    logic [1:0]  fg_ptr_q, fg_ptr_d;
    logic [1:0]  bg_ptr_q, bg_ptr_d;
    logic [31:0] prdata_q, prdata_d;
    logic        pready_q, pready_d;
    logic        pslverr_q, pslverr_d;
    logic        access;
    logic        unlocked;
    logic [7:0]  rbyte;
    logic [7:0]  wbyte;

    always_comb begin
        lock_d    = lock_q;
        mode_d    = mode_q;
        xh_d      = xh_q;
        xl_d      = xl_q;
        yh_d      = yh_q;
        yl_d      = yl_q;
        segh_d    = segh_q;
        segl_d    = segl_q;
        xoff_d    = xoff_q;
        yoff_d    = yoff_q;
        dac_d     = dac_q;
        adv_d     = adv_q;
        fg_d      = fg_q;
        bg_d      = bg_q;
        fg_ptr_d  = fg_ptr_q;
        bg_ptr_d  = bg_ptr_q;
        wbyte     = pwdata[7:0];
        unlocked  = (lock_q == hco_pkg::UNLOCK_KEY);
        access    = psel && penable && pready_q;
        // Answer is prepared in setup so prdata comes straight from a flop
        pready_d  = psel && !penable;
        pslverr_d = psel && !penable && !is_mapped(paddr);
        // Stack reads leave the pointer alone
        unique case (paddr)
            hco_pkg::ADDR_LOCK:     rbyte = lock_q;
            hco_pkg::ADDR_MODE:     rbyte = mode_q;
            hco_pkg::ADDR_X_HIGH:   rbyte = xh_q;
            hco_pkg::ADDR_X_LOW:    rbyte = xl_q;
            hco_pkg::ADDR_Y_HIGH:   rbyte = yh_q;
            hco_pkg::ADDR_Y_LOW:    rbyte = yl_q;
            hco_pkg::ADDR_FG_STACK: rbyte = fg_q[fg_ptr_q];
            hco_pkg::ADDR_BG_STACK: rbyte = bg_q[bg_ptr_q];
            hco_pkg::ADDR_SEG_HIGH: rbyte = segh_q;
            hco_pkg::ADDR_SEG_LOW:  rbyte = segl_q;
            hco_pkg::ADDR_X_OFFSET: rbyte = xoff_q;
            hco_pkg::ADDR_Y_OFFSET: rbyte = yoff_q;
            hco_pkg::ADDR_DAC_CTRL: rbyte = dac_q;
            hco_pkg::ADDR_ADV_FUNC: rbyte = adv_q;
            default:                rbyte = hco_pkg::REG_RESET;
        endcase
        prdata_d = (psel && !penable) ? {24'h000000, rbyte} : prdata_q;
        if (access && !pwrite && (paddr == hco_pkg::ADDR_MODE)) begin
            fg_ptr_d = hco_pkg::STACK_FIRST;
            bg_ptr_d = hco_pkg::STACK_FIRST;
        end
        if (access && pwrite && is_mapped(paddr) && (unlocked || !is_locked_reg(paddr))) begin
            unique case (paddr)
                hco_pkg::ADDR_LOCK:     lock_d = wbyte;
                hco_pkg::ADDR_MODE:     mode_d = wbyte;
                hco_pkg::ADDR_X_HIGH:   xh_d   = {5'h00, wbyte[2:0]};
                hco_pkg::ADDR_X_LOW:    xl_d   = wbyte;
                hco_pkg::ADDR_Y_HIGH:   yh_d   = {5'h00, wbyte[2:0]};
                hco_pkg::ADDR_Y_LOW:    yl_d   = wbyte;
                hco_pkg::ADDR_FG_STACK: begin
                    fg_d[fg_ptr_q] = wbyte;
                    fg_ptr_d = (fg_ptr_q == hco_pkg::STACK_LAST) ? hco_pkg::STACK_FIRST :
                               fg_ptr_q + 2'h1;
                end
                hco_pkg::ADDR_BG_STACK: begin
                    bg_d[bg_ptr_q] = wbyte;
                    bg_ptr_d = (bg_ptr_q == hco_pkg::STACK_LAST) ? hco_pkg::STACK_FIRST :
                               bg_ptr_q + 2'h1;
                end
                hco_pkg::ADDR_SEG_HIGH: segh_d = {4'h0, wbyte[3:0]};
                hco_pkg::ADDR_SEG_LOW:  segl_d = wbyte;
                hco_pkg::ADDR_X_OFFSET: xoff_d = {2'h0, wbyte[5:0]};
                hco_pkg::ADDR_Y_OFFSET: yoff_d = {2'h0, wbyte[5:0]};
                hco_pkg::ADDR_DAC_CTRL: dac_d  = wbyte;
                hco_pkg::ADDR_ADV_FUNC: adv_d  = wbyte;
                default:                lock_d = lock_q;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            lock_q    <= hco_pkg::REG_RESET;
            mode_q    <= hco_pkg::REG_RESET;
            xh_q      <= hco_pkg::REG_RESET;
            xl_q      <= hco_pkg::REG_RESET;
            yh_q      <= hco_pkg::REG_RESET;
            yl_q      <= hco_pkg::REG_RESET;
            segh_q    <= hco_pkg::REG_RESET;
            segl_q    <= hco_pkg::REG_RESET;
            xoff_q    <= hco_pkg::REG_RESET;
            yoff_q    <= hco_pkg::REG_RESET;
            dac_q     <= hco_pkg::REG_RESET;
            adv_q     <= hco_pkg::REG_RESET;
            fg_q      <= '{default: hco_pkg::REG_RESET};
            bg_q      <= '{default: hco_pkg::REG_RESET};
            fg_ptr_q  <= hco_pkg::STACK_FIRST;
            bg_ptr_q  <= hco_pkg::STACK_FIRST;
            prdata_q  <= 32'h00000000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            lock_q    <= lock_d;
            mode_q    <= mode_d;
            xh_q      <= xh_d;
            xl_q      <= xl_d;
            yh_q      <= yh_d;
            yl_q      <= yl_d;
            segh_q    <= segh_d;
            segl_q    <= segl_d;
            xoff_q    <= xoff_d;
            yoff_q    <= yoff_d;
            dac_q     <= dac_d;
            adv_q     <= adv_d;
            fg_q      <= fg_d;
            bg_q      <= bg_d;
            fg_ptr_q  <= fg_ptr_d;
            bg_ptr_q  <= bg_ptr_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // ********************************************************
    // Frame latch and per-line mask fetch
    // ********************************************************
    hco_pkg::hco_pos_t         pos_q, pos_d;
    hco_pkg::hco_fetch_t       ft_q, ft_d;
    logic                      req_q, req_d;
    logic [hco_pkg::MEM_AW-1:0] addr_q, addr_d;
    logic [63:0]               and_row_q, and_row_d;
    logic [63:0]               xor_row_q, xor_row_d;
    logic                      row_ok_q, row_ok_d;
    logic [11:0]               row;
    logic                      row_hit;
    logic [hco_pkg::MEM_AW-1:0] base;

    always_comb begin
        pos_d     = pos_q;
        ft_d      = ft_q;
        req_d     = req_q;
        addr_d    = addr_q;
        and_row_d = and_row_q;
        xor_row_d = xor_row_q;
        row_ok_d  = row_ok_q;
        if (frame_start) begin
            // Latched only here so a mid-frame write cannot tear the cursor
            pos_d.x    = {xh_q[2:0], xl_q};
            pos_d.y    = {yh_q[2:0], yl_q};
            pos_d.xoff = xoff_q[5:0];
            pos_d.yoff = yoff_q[5:0];
        end
        row     = {1'b0, line_y - pos_q.y} + {6'h00, pos_q.yoff};
        row_hit = (line_y >= pos_q.y) && (row < hco_pkg::CURSOR_SIZE) &&
                  (pos_q.y < hco_pkg::SCREEN_H);
        base    = {segh_q[3:0], segl_q, 10'h000};
        unique case (ft_q)
            hco_pkg::FT_IDLE: begin
                if (line_fetch) begin
                    // Cursor stays off until both rows are in
                    row_ok_d = 1'b0;
                    if (row_hit) begin
                        ft_d   = hco_pkg::FT_AND;
                        req_d  = 1'b1;
                        addr_d = base + {13'h0000, row[5:0], 3'h0};
                    end
                end
            end
            hco_pkg::FT_AND: begin
                if (mem_ack) begin
                    and_row_d = mem_rdata;
                    addr_d    = addr_q + hco_pkg::XOR_MASK_OFS;
                    ft_d      = hco_pkg::FT_XOR;
                end
            end
            hco_pkg::FT_XOR: begin
                if (mem_ack) begin
                    xor_row_d = mem_rdata;
                    req_d     = 1'b0;
                    row_ok_d  = 1'b1;
                    ft_d      = hco_pkg::FT_IDLE;
                end
            end
            default: ft_d = hco_pkg::FT_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pos_q     <= '0;
            ft_q      <= hco_pkg::FT_IDLE;
            req_q     <= 1'b0;
            addr_q    <= '0;
            and_row_q <= 64'h0000000000000000;
            xor_row_q <= 64'h0000000000000000;
            row_ok_q  <= 1'b0;
        end else begin
            pos_q     <= pos_d;
            ft_q      <= ft_d;
            req_q     <= req_d;
            addr_q    <= addr_d;
            and_row_q <= and_row_d;
            xor_row_q <= xor_row_d;
            row_ok_q  <= row_ok_d;
        end
    end

    assign mem_req  = req_q;
    assign mem_addr = addr_q;

    // ********************************************************
    // Pixel combiner
    // ********************************************************
    hco_pkg::hco_pix_t pix_q, pix_d;
    logic [11:0]       col;
    logic              col_hit;
    logic [5:0]        bit_idx;
    logic              and_bit;
    logic              xor_bit;
    logic [23:0]       fg_rgb;
    logic [23:0]       bg_rgb;
    logic              shown;

    always_comb begin
        col     = {1'b0, pix_x - pos_q.x} + {6'h00, pos_q.xoff};
        col_hit = (pix_x >= pos_q.x) && (col < hco_pkg::CURSOR_SIZE);
        // Byte k of the row word is byte k in memory; its MSB is leftmost
        bit_idx = {col[5:3], ~col[2:0]};
        and_bit = and_row_q[bit_idx];
        xor_bit = xor_row_q[bit_idx];
        fg_rgb  = {fg_q[2], fg_q[1], fg_q[0]};
        bg_rgb  = {bg_q[2], bg_q[1], bg_q[0]};
        shown   = mode_q[hco_pkg::ENABLE_BIT] && adv_q[hco_pkg::ENHANCED_BIT] &&
                  row_ok_q && col_hit && pix_in.active;
        pix_d   = pix_in;
        if (shown) begin
            if (!dac_q[hco_pkg::CONVENTION_BIT]) begin
                unique case ({and_bit, xor_bit})
                    2'b00: pix_d.rgb = bg_rgb;
                    2'b01: pix_d.rgb = fg_rgb;
                    2'b10: pix_d.rgb = pix_in.rgb;
                    2'b11: pix_d.rgb = ~pix_in.rgb;
                endcase
            end else if (and_bit) begin
                pix_d.rgb = xor_bit ? fg_rgb : bg_rgb;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pix_q <= '0;
        end else begin
            pix_q <= pix_d;
        end
    end

    assign pix_out = pix_q;
endmodule
`default_nettype wire

/* File: test/hco_overlay_assertions.sv */
// Port checker for the cursor overlay, bound into every hco_overlay instance
`timescale 1ns/10ps
`default_nettype none
module hco_overlay_chk (
    // Clock and reset
    input wire logic              ref_clk,
    input wire logic              reset_n,
    // APB
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [7:0]        paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // Display side
    input wire logic              frame_start,
    input wire logic              line_fetch,
    input wire logic [10:0]       line_y,
    input wire logic [10:0]       pix_x,
    input wire hco_pkg::hco_pix_t pix_in,
    input wire hco_pkg::hco_pix_t pix_out,
    // Memory port
    input wire logic              mem_req,
    input wire logic [21:0]       mem_addr,
    input wire logic              mem_ack,
    input wire logic [63:0]       mem_rdata
);
    // ********
    // Properties
    // ********
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    property p_ready;
        psel && !penable |=> pready ##1 !pready;
    endproperty
    a_ready: assert property (p_ready) else $error("pready not one cycle after setup");
    property p_rdhi;
        pready |-> prdata[31:8] == 24'h0;
    endproperty
    a_rdhi: assert property (p_rdhi) else $error("read data above byte");
    property p_cause;
        $rose(mem_req) |-> $past(line_fetch);
    endproperty
    a_cause: assert property (p_cause) else $error("fetch without line start");
    property p_first;
        $rose(mem_req) |-> !mem_addr[9] && mem_addr[2:0] == 3'h0;
    endproperty
    a_first: assert property (p_first) else $error("fetch not at AND row");
    property p_hold;
        mem_req && !mem_ack |=> mem_req && $stable(mem_addr);
    endproperty
    a_hold: assert property (p_hold) else $error("request dropped before ack");
    property p_xor;
        mem_req && mem_ack && !mem_addr[9] |=> mem_req && mem_addr == $past(mem_addr) + 22'h200;
    endproperty
    a_xor: assert property (p_xor) else $error("XOR row not 512 bytes on");
    property p_done;
        mem_req && mem_ack && mem_addr[9] |=> !mem_req;
    endproperty
    a_done: assert property (p_done) else $error("request after XOR ack");
    property p_fall;
        $fell(mem_req) |-> $past(mem_ack);
    endproperty
    a_fall: assert property (p_fall) else $error("request fell without ack");
    property p_pass;
        !pix_in.active |=> pix_out == $past(pix_in);
    endproperty
    a_pass: assert property (p_pass) else $error("blank pixel altered");
    c_fetch: cover property (mem_req && mem_ack && mem_addr[9]);
    c_err: cover property (pready && pslverr);
    c_frame: cover property (frame_start ##1 !frame_start);
endmodule
bind hco_overlay hco_overlay_chk u_chk (
    .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_start(frame_start), .line_fetch(line_fetch), .line_y(line_y), .pix_x(pix_x),
    .pix_in(pix_in), .pix_out(pix_out), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata)
);
`default_nettype wire

/* File: test/hco_mem_model.sv */
// Display memory model holding the cursor masks
`timescale 1ns/10ps
`default_nettype none
module hco_mem_model (
    // Clock, reset, answer delay
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic [3:0]  lat,
    // Read port
    input  wire logic        mem_req,
    input  wire logic [21:0] mem_addr,
    output var  logic        mem_ack,
    output var  logic [63:0] mem_rdata
);
    // ********
    // Masks: AND rows alternate 0f/f0, XOR rows 33
    // ********
    logic [3:0] wait_q;
    function automatic logic [7:0] mbyte(input logic [21:0] a);
        return a[9] ? 8'h33 : (a[3] ? 8'hf0 : 8'h0f);
    endfunction
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            mem_ack <= 1'b0;
            wait_q <= 4'h0;
            mem_rdata <= 64'h0;
        end else begin
            mem_ack <= 1'b0;
            // Idle data toggles so stale bytes never look valid
            mem_rdata <= ~mem_rdata;
            if (mem_req && !mem_ack) begin
                if (wait_q == lat) begin
                    mem_ack <= 1'b1;
                    wait_q <= 4'h0;
                    for (int k = 0; k < 8; k++)
                        mem_rdata[8*k +: 8] <= mbyte(mem_addr + 22'(k));
                end else begin
                    wait_q <= wait_q + 4'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: test/hco_overlay_tb_top.sv */
// Self-checking bench for the cursor overlay
`timescale 1ns/10ps
`default_nettype none
module hco_overlay_tb_top;
    logic ref_clk, reset_n, psel, penable, pwrite, pready, pslverr;
    logic frame_start, line_fetch, mem_req, mem_ack, typeb;
    logic [7:0] paddr, andb;
    logic [31:0] pwdata, prdata;
    logic [10:0] line_y, pix_x;
    logic [21:0] mem_addr;
    logic [63:0] mem_rdata;
    logic [3:0] mem_lat;
    hco_pkg::hco_pix_t pix_in, pix_out;
    int fails, checks;
    localparam logic [23:0] SCR = 24'h123456, FG = 24'h332244, BG = 24'h776655;
    localparam logic [21:0] BASE = 22'h0ff800;

    hco_overlay dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .frame_start(frame_start), .line_fetch(line_fetch), .line_y(line_y), .pix_x(pix_x),
        .pix_in(pix_in), .pix_out(pix_out), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata)
    );
    hco_mem_model u_mem (
        .ref_clk(ref_clk), .reset_n(reset_n), .lat(mem_lat), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata)
    );

    // ********
    // Helpers
    // ********
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic summarize;
        if (fails == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] x);
        checks++;
        if (got !== x) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, x);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [31:0] rd, output logic er);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        for (n = 0; n < 16 && pready !== 1'b1; n++) @(posedge ref_clk);
        rd = prdata;
        er = pslverr;
        if (n == 16) begin
            check(32'(n), 32'h0);
            summarize;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 8'h00, r, e);
        check(r, x);
    endtask
    task automatic frame;
        frame_start <= 1'b1;
        @(posedge ref_clk);
        frame_start <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic fetch(input logic [10:0] y, input logic hit, input logic [21:0] ea);
        int n;
        line_y <= y;
        line_fetch <= 1'b1;
        @(posedge ref_clk);
        line_fetch <= 1'b0;
        #1;
        check({31'h0, mem_req}, {31'h0, hit});
        if (hit)
            check({10'h0, mem_addr}, {10'h0, ea});
        for (n = 0; n < 40 && mem_req !== 1'b0; n++) @(posedge ref_clk);
        if (n == 40) begin
            check(32'(n), 32'h0);
            summarize;
        end
        @(posedge ref_clk);
    endtask
    function automatic logic [23:0] cur(input int c);
        logic a, x;
        a = andb[7 - c % 8];
        x = 8'h33 >> (7 - c % 8);
        if (typeb)
            return a ? (x ? FG : BG) : SCR;
        return a ? (x ? ~SCR : SCR) : (x ? FG : BG);
    endfunction
    task automatic pix(input logic [10:0] x, input logic act, input logic [23:0] e);
        pix_x <= x;
        pix_in <= {act, SCR};
        @(posedge ref_clk);
        #1;
        check({7'h0, pix_out}, {7'h0, act, e});
        @(posedge ref_clk);
    endtask

    // ********
    // Scenarios
    // ********
    task automatic t_regs;
        logic [31:0] r;
        logic e;
        for (int a = 0; a < 'h38; a += 4) rdchk(8'(a), 32'h0);
        wr(hco_pkg::ADDR_X_LOW, 8'hab);
        rdchk(hco_pkg::ADDR_X_LOW, 32'h0);
        wr(hco_pkg::ADDR_LOCK, 8'ha0);
        wr(hco_pkg::ADDR_X_HIGH, 8'hff);
        rdchk(hco_pkg::ADDR_X_HIGH, 32'h7);
        wr(hco_pkg::ADDR_X_OFFSET, 8'hff);
        rdchk(hco_pkg::ADDR_X_OFFSET, 32'h3f);
        wr(hco_pkg::ADDR_SEG_HIGH, 8'hff);
        rdchk(hco_pkg::ADDR_SEG_HIGH, 32'hf);
        wr(hco_pkg::ADDR_LOCK, 8'h00);
        wr(hco_pkg::ADDR_Y_LOW, 8'h55);
        rdchk(hco_pkg::ADDR_Y_LOW, 32'h0);
        apb(1'b0, 8'h38, 8'h00, r, e);
        check({31'h0, e}, 32'h1);
        wr(hco_pkg::ADDR_LOCK, 8'ha0);
    endtask
    task automatic t_stack;
        rdchk(hco_pkg::ADDR_MODE, 32'h0);
        for (int i = 1; i < 5; i++) wr(hco_pkg::ADDR_FG_STACK, 8'(i * 'h11));
        rdchk(hco_pkg::ADDR_FG_STACK, 32'h22);
        rdchk(hco_pkg::ADDR_MODE, 32'h0);
        rdchk(hco_pkg::ADDR_FG_STACK, 32'h44);
        for (int i = 5; i < 8; i++) wr(hco_pkg::ADDR_BG_STACK, 8'(i * 'h11));
        rdchk(hco_pkg::ADDR_BG_STACK, 32'h55);
    endtask
    task automatic t_frame;
        wr(hco_pkg::ADDR_SEG_HIGH, 8'h03);
        wr(hco_pkg::ADDR_SEG_LOW, 8'hfe);
        wr(hco_pkg::ADDR_X_HIGH, 8'h00);
        wr(hco_pkg::ADDR_X_LOW, 8'h10);
        wr(hco_pkg::ADDR_X_OFFSET, 8'h00);
        wr(hco_pkg::ADDR_MODE, 8'h01);
        wr(hco_pkg::ADDR_ADV_FUNC, 8'h01);
        frame;
        wr(hco_pkg::ADDR_Y_LOW, 8'h04);
        fetch(11'd4, 1'b1, BASE + 22'h20);
        frame;
        fetch(11'd4, 1'b1, BASE);
        andb = 8'h0f;
        typeb = 1'b0;
        for (int c = 0; c < 16; c++) pix(11'(16 + c), 1'b1, cur(c));
        pix(11'd15, 1'b1, SCR);
        pix(11'd80, 1'b1, SCR);
        pix(11'd16, 1'b0, SCR);
        wr(hco_pkg::ADDR_ADV_FUNC, 8'h00);
        pix(11'd16, 1'b1, SCR);
        wr(hco_pkg::ADDR_ADV_FUNC, 8'h01);
        wr(hco_pkg::ADDR_MODE, 8'h00);
        pix(11'd16, 1'b1, SCR);
        wr(hco_pkg::ADDR_MODE, 8'h01);
        pix(11'd16, 1'b1, BG);
        wr(hco_pkg::ADDR_DAC_CTRL, 8'h10);
        typeb = 1'b1;
        for (int c = 0; c < 8; c++) pix(11'(16 + c), 1'b1, cur(c));
    endtask
    task automatic t_offset;
        wr(hco_pkg::ADDR_X_OFFSET, 8'h04);
        wr(hco_pkg::ADDR_Y_OFFSET, 8'h01);
        frame;
        mem_lat <= 4'h5;
        fetch(11'd4, 1'b1, BASE + 22'h8);
        andb = 8'hf0;
        for (int c = 0; c < 8; c++) pix(11'(16 + c), 1'b1, cur(c + 4));
        pix(11'd76, 1'b1, SCR);
        fetch(11'd67, 1'b0, BASE);
    endtask
    task automatic t_bottom;
        wr(hco_pkg::ADDR_Y_OFFSET, 8'h00);
        wr(hco_pkg::ADDR_Y_HIGH, 8'h02);
        wr(hco_pkg::ADDR_Y_LOW, 8'hff);
        frame;
        fetch(11'd767, 1'b1, BASE);
        wr(hco_pkg::ADDR_Y_HIGH, 8'h03);
        wr(hco_pkg::ADDR_Y_LOW, 8'h00);
        frame;
        fetch(11'd768, 1'b0, BASE);
    endtask

    initial begin
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        frame_start = 1'b0;
        line_fetch = 1'b0;
        line_y = 11'h0;
        pix_x = 11'h0;
        pix_in = '0;
        mem_lat = 4'h0;
        typeb = 1'b0;
        andb = 8'h00;
        fails = 0;
        checks = 0;
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        t_regs;
        t_stack;
        t_frame;
        t_offset;
        t_bottom;
        summarize;
    end
endmodule
`default_nettype wire
